/* File: pwm_timer_cfg.svh */
// Purpose: constants for the six channel pwm timer
// Assumes: included by pwm_timer_pkg and the design
// Notes: timing counts are in clk cycles
`ifndef PWM_TIMER_CFG_SVH
`define PWM_TIMER_CFG_SVH
`define PWM_CHANNELS 6
`define PWM_COUNT_WIDTH 16
`define PWM_RATE_WIDTH 3
`define PWM_PRESCALE_WIDTH 7
`define PWM_PERIOD_RESET 16'h0000
`define PWM_DUTY_RESET 16'h0000
`define PWM_SYNC_CYCLES 2
`endif

/* File: pwm_timer_pkg.sv */
// Purpose: types for the six channel pwm timer
// Assumes: pwm_timer_cfg.svh constants
// Notes: none
`include "pwm_timer_cfg.svh"
package pwm_timer_pkg;
   typedef logic [`PWM_COUNT_WIDTH-1:0] count_type;
   typedef logic [`PWM_CHANNELS-1:0] chan_bits_type;
   typedef logic [`PWM_RATE_WIDTH-1:0] rate_type;
   typedef enum logic [1:0] {
      st_off = 2'b00,
      st_sync = 2'b01,
      st_run = 2'b11,
      st_stall = 2'b10
   } run_state_type;
endpackage

/* File: six_channel_pwm_timer.sv */
// Purpose: 16-bit period timer driving six pwm channels on shared pins
// Assumes: one clock (fosc), synchronous active high reset, firmware bytes as strobes
// Notes: outputs are registered; pins carry gpio level when not routed
`timescale 1ns/1ps
`default_nettype none
`include "pwm_timer_cfg.svh"

// How it works
// (R1) 16-bit up counter clears after period minus one and raises wrap request
// (R2) six channels, each own duty register, sharing one period counter
// (R3) route bit set selects pwm on pin; cleared gives held gpio level
// (R4) wrap request with interrupt enabled asserts idle wake output
// (R5) wrap flag set at once; firmware writes it; enable gates request
// (R6) pins switch to pwm only after internal output sync completes
// (R7) timer enable low returns every channel to gpio level
// (R8) outputs start each cycle high when counter begins from zero
// (R9) counter equal to duty drives channel low, counter keeps counting
// (R10) counter reloads to zero after period minus one, outputs high again
// (R11) firmware keeps every duty not above period value
// (R12) prescale code 000 divides by 128, each step halves, 111 by 1
// (R13) invert bit outputs logical inverse of channel waveform
// (R14) half rate bit outputs channel at half base frequency
// (R15) zero period at enable stops timer and freezes period
// (R16) firmware finishes period setup before enabling timer
// (R17) half rate toggles pattern on alternate counter cycles
// (R18) period and duty written as bytes, compared as 16 bits
module six_channel_pwm_timer
   import pwm_timer_pkg::*;
#(
   parameter int channels = `PWM_CHANNELS
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic pwm_timer_enable,
   input wire pwm_timer_pkg::rate_type prescale_select,
   input wire pwm_timer_pkg::chan_bits_type pin_route_select,
   input wire pwm_timer_pkg::chan_bits_type output_invert,
   input wire pwm_timer_pkg::chan_bits_type half_rate_select,
   input wire pwm_timer_pkg::chan_bits_type gpio_level,
   input wire logic wrap_irq_enable,
   input wire logic [7:0] wr_data,
   input wire logic period_lo_wr,
   input wire logic period_hi_wr,
   input wire pwm_timer_pkg::chan_bits_type duty_lo_wr,
   input wire pwm_timer_pkg::chan_bits_type duty_hi_wr,
   input wire logic flag_wr,
   input wire logic flag_wr_value,
   output logic [`PWM_CHANNELS-1:0] pwm_out_pin,
   output logic [`PWM_COUNT_WIDTH-1:0] period_counter,
   output logic period_wrap_flag,
   output logic wrap_request_flag,
   output logic idle_wake
);
   import pwm_timer_pkg::*;

   typedef struct packed {
      run_state_type state;
      logic [`PWM_PRESCALE_WIDTH-1:0] pre;
      logic [1:0] sync_cnt;
      count_type period_value;
      count_type [`PWM_CHANNELS-1:0] channel_duty;
      count_type cnt;
      chan_bits_type wave;
      chan_bits_type half_phase;
      chan_bits_type pins;
      logic flag;
      logic req;
      logic wake;
   } state_type;

   state_type cur, nxt;

   // prescale terminal count: 128 >> code, minus one
   function automatic logic [`PWM_PRESCALE_WIDTH-1:0] pre_limit(input rate_type code);
      logic [7:0] div;
      div = 8'h80 >> code;
      return div[`PWM_PRESCALE_WIDTH-1:0] - 7'h01;
   endfunction

   function automatic count_type set_byte(input count_type v, input logic hi,
                                          input logic [7:0] b);
      count_type r;
      r = v;
      if (hi) begin
         r[15:8] = b;
      end else begin
         r[7:0] = b;
      end
      return r;
   endfunction

   logic tick;
   logic wrap;
   chan_bits_type shaped;
   logic [`PWM_COUNT_WIDTH:0] pos;

   always_comb begin
      nxt = cur;
      tick = 1'b0;
      wrap = 1'b0;
      shaped = '0;
      pos = '0;
      // byte-wide writes, compare uses full word [R18]
      if (cur.state != st_stall) begin // [R15]
         if (period_lo_wr) nxt.period_value = set_byte(cur.period_value, 1'b0, wr_data); // [R18]
         if (period_hi_wr) nxt.period_value = set_byte(cur.period_value, 1'b1, wr_data); // [R18]
      end
      for (int i = 0; i < channels; i++) begin
         if (duty_lo_wr[i]) nxt.channel_duty[i] = set_byte(cur.channel_duty[i], 1'b0, wr_data); // [R2]
         if (duty_hi_wr[i]) nxt.channel_duty[i] = set_byte(cur.channel_duty[i], 1'b1, wr_data); // [R18]
      end
      unique case (cur.state)
         st_off: begin
            nxt.cnt = '0;
            nxt.pre = '0;
            nxt.wave = '1;
            nxt.half_phase = '0;
            nxt.sync_cnt = '0;
            if (pwm_timer_enable) begin
               if (cur.period_value == '0) nxt.state = st_stall; // [R15]
               else nxt.state = st_sync;
            end
         end
         st_sync: begin
            nxt.sync_cnt = cur.sync_cnt + 2'd1;
            if (!pwm_timer_enable) nxt.state = st_off;
            else if (cur.sync_cnt == 2'(`PWM_SYNC_CYCLES - 1)) nxt.state = st_run; // [R6]
         end
         st_run: begin
            if (!pwm_timer_enable) begin
               nxt.state = st_off; // [R7]
            end else begin
               tick = (cur.pre >= pre_limit(prescale_select)); // [R12]
               nxt.pre = tick ? '0 : cur.pre + 7'h01;
               if (tick) begin
                  wrap = (cur.cnt >= cur.period_value - 16'h0001); // [R10]
                  nxt.cnt = wrap ? '0 : cur.cnt + 16'h0001; // [R1]
                  for (int i = 0; i < channels; i++) begin
                     if (wrap) begin
                        nxt.wave[i] = 1'b1; // [R8]
                        nxt.half_phase[i] = ~cur.half_phase[i]; // [R17]
                     end else if (cur.cnt + 16'h0001 == cur.channel_duty[i]) begin
                        nxt.wave[i] = 1'b0; // [R9]
                     end
                  end
               end
            end
         end
         st_stall: begin
            if (!pwm_timer_enable) nxt.state = st_off;
         end
      endcase
      // half rate: two counter cycles form one pwm period at the same duty proportion
      for (int i = 0; i < channels; i++) begin
         pos = cur.half_phase[i] ? {1'b0, cur.cnt} + {1'b0, cur.period_value}
                                 : {1'b0, cur.cnt};
         shaped[i] = half_rate_select[i] ? (pos < {cur.channel_duty[i], 1'b0}) // [R14] [R17]
                                          : cur.wave[i];
         shaped[i] = shaped[i] ^ output_invert[i]; // [R13]
         nxt.pins[i] = (pin_route_select[i] && cur.state == st_run) ? shaped[i] // [R3]
                                                                     : gpio_level[i]; // [R7]
      end
      nxt.flag = wrap ? 1'b1 : (flag_wr ? flag_wr_value : cur.flag); // [R5]
      nxt.req = nxt.flag & wrap_irq_enable; // [R5]
      nxt.wake = wrap & wrap_irq_enable; // [R4]
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cur <= '0;
         cur.period_value <= `PWM_PERIOD_RESET;
         cur.wave <= '1;
      end else if (clk_en) begin
         cur <= nxt;
      end
   end

   assign pwm_out_pin = cur.pins;
   assign period_counter = cur.cnt;
   assign period_wrap_flag = cur.flag;
   assign wrap_request_flag = cur.req;
   assign idle_wake = cur.wake;

   chk_wrap_clears: assert property (@(posedge clk) disable iff (sys_rst) // [R1]
      (clk_en && cur.state == st_run && pwm_timer_enable && tick && wrap)
      |=> (cur.cnt == '0 && cur.flag))
      else $error("counter did not clear with flag on wrap");
   chk_flag_set_wins: assert property (@(posedge clk) disable iff (sys_rst) // [R5]
      (clk_en && wrap) |=> cur.flag)
      else $error("wrap flag lost");
   chk_wake_gate: assert property (@(posedge clk) disable iff (sys_rst) // [R4]
      (clk_en && wrap && wrap_irq_enable) |=> idle_wake)
      else $error("wake missing");
   chk_req_gated: assert property (@(posedge clk) disable iff (sys_rst) // [R5]
      (clk_en && !wrap_irq_enable) |=> !wrap_request_flag)
      else $error("request while disabled");
   chk_sync_delay: assert property (@(posedge clk) disable iff (sys_rst) // [R6]
      $rose(cur.state == st_run)
      |-> ($past(cur.state, 1) == st_sync && $past(cur.state, 2) == st_sync))
      else $error("pwm before sync");
   chk_route_gpio: assert property (@(posedge clk) disable iff (sys_rst) // [R3]
      (clk_en && !pin_route_select[0]) |=> (pwm_out_pin[0] == $past(gpio_level[0])))
      else $error("unrouted pin not gpio");
   chk_stall_frozen: assert property (@(posedge clk) disable iff (sys_rst) // [R15]
      (clk_en && cur.state == st_stall) |=> $stable(cur.period_value))
      else $error("period changed while stalled");
   chk_gpio_off: assert property (@(posedge clk) disable iff (sys_rst) // [R7]
      (clk_en && cur.state != st_run) |=> (pwm_out_pin == $past(gpio_level)))
      else $error("pins not gpio while stopped");
   chk_stall_zero: assert property (@(posedge clk) disable iff (sys_rst) // [R15]
      (clk_en && cur.state == st_off && pwm_timer_enable && cur.period_value == '0)
      |=> cur.state == st_stall)
      else $error("zero period did not stall");
   chk_high_start: assert property (@(posedge clk) disable iff (sys_rst) // [R8]
      (clk_en && tick && wrap) |=> (cur.wave == '1))
      else $error("wave not high at cycle start");
   chk_duty_low: assert property (@(posedge clk) disable iff (sys_rst) // [R9]
      (clk_en && tick && !wrap && cur.cnt + 16'h0001 == cur.channel_duty[0])
      |=> !cur.wave[0])
      else $error("channel did not drop at duty");
endmodule // six_channel_pwm_timer
`default_nettype wire

/* File: pwm_load_model.sv */
// Purpose: load on the six pwm pins, counts high cycles per pin
// Assumes: one sample per clk edge
// Notes: counts clear while clr is high
`timescale 1ns/1ps
`default_nettype none
module pwm_load_model (
   input wire logic clk,
   input wire logic clr,
   input wire logic [5:0] pin,
   output var logic [15:0] hi_cnt [6]
);
   always_ff @(posedge clk) begin
      for (int i = 0; i < 6; i++) begin
         hi_cnt[i] <= clr ? 16'h0000 : hi_cnt[i] + 16'(pin[i]);
      end
   end
endmodule // pwm_load_model
`default_nettype wire

/* File: six_channel_pwm_timer_tb.sv */
// Purpose: self-checking bench for the six channel pwm timer
// Assumes: fixed seed, prescale codes 7 and 4 to 6 exercised
// Notes: high-time windows span whole double periods
`timescale 1ns/1ps
`default_nettype none
module six_channel_pwm_timer_tb;
   import pwm_timer_pkg::*;
   logic clk = 0, sys_rst = 1, clk_en = 1, en = 0, ien = 0, clr = 1;
   logic plo = 0, phi = 0, fwr = 0, fval = 0, flag, req, wake;
   rate_type rate = 3'h7;
   chan_bits_type route = 0, inv = 0, half = 0, gpio = 0, dlo = 0, dhi = 0, pin;
   logic [7:0] wd = 0;
   count_type cnt, cmax;
   logic [15:0] hi [6];
   int n_fail = 0, compares = 0, cyc = 0, p, k, t;
   int d [6];
   always #20 clk = ~clk;
   six_channel_pwm_timer i_six_channel_pwm_timer (.clk, .sys_rst, .clk_en,
      .pwm_timer_enable(en), .prescale_select(rate), .pin_route_select(route),
      .output_invert(inv), .half_rate_select(half), .gpio_level(gpio),
      .wrap_irq_enable(ien), .wr_data(wd), .period_lo_wr(plo), .period_hi_wr(phi),
      .duty_lo_wr(dlo), .duty_hi_wr(dhi), .flag_wr(fwr), .flag_wr_value(fval),
      .pwm_out_pin(pin), .period_counter(cnt), .period_wrap_flag(flag),
      .wrap_request_flag(req), .idle_wake(wake));
   pwm_load_model i_pwm_load_model (.clk, .clr, .pin, .hi_cnt(hi));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task tally_and_finish;
      if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // channel 6 selects the period
   task automatic wr16(input logic [15:0] v, input int ch);
      chan_bits_type m;
      m = chan_bits_type'(6'h01 << ch);
      @(posedge clk);
      wd <= v[7:0];
      plo <= (ch == 6);
      dlo <= m;
      @(posedge clk);
      wd <= v[15:8];
      plo <= 0;
      dlo <= 0;
      phi <= (ch == 6);
      dhi <= m;
      @(posedge clk);
      phi <= 0;
      dhi <= 0;
   endtask
   task automatic wait_wake(output int n);
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (wake !== 1'b1 && n < 3000);
   endtask
   function automatic int exp_hi(int p, int d, int w, logic i, logic h);
      exp_hi = h ? w / (2 * p) * (2 * d) : w / p * d;
      if (i) exp_hi = w - exp_hi;
   endfunction
   always @(posedge clk) begin
      cyc++;
      cmax <= clr ? 16'h0000 : (cnt > cmax ? cnt : cmax);
      if (cyc == 20000) begin
         n_fail++;
         tally_and_finish();
      end
   end
   initial begin
      void'($urandom(46));
      repeat (4) @(posedge clk);
      sys_rst <= 0;
      repeat (2) @(posedge clk);
      #1;
      chk({pin, flag, cnt}, 0);
      wr16(16'h0000, 6);
      en <= 1;
      wr16(16'h0005, 6);
      repeat (10) @(posedge clk);
      #1;
      chk(cnt, 0);
      for (t = 0; t < 3; t++) begin
         @(posedge clk);
         en <= 0;
         ien <= 0;
         @(posedge clk);
         p = (t == 0) ? 4 : 4 + $urandom % 12;
         wr16(16'(p), 6);
         for (int c = 0; c < 6; c++) begin
            d[c] = (t == 0 && c < 2) ? (c ? p : 1) : 1 + $urandom % p;
            wr16(16'(d[c]), c);
         end
         {route, inv, half, gpio} <= 24'($urandom);
         rate <= 3'h7;
         ien <= 1;
         en <= 1;
         repeat (2 * p + 8) @(posedge clk);
         clr <= 0;
         repeat (4 * p) @(posedge clk);
         clr <= 1;
         rate <= 3'(4 + t);
         #1;
         for (int c = 0; c < 6; c++) begin
            chk(hi[c], route[c] ? exp_hi(p, d[c], 4 * p, inv[c], half[c])
               : (gpio[c] ? 4 * p : 0));
         end
         chk(cmax, p - 1);
         chk(flag, 1);
         repeat (2) wait_wake(k);
         wait_wake(k);
         chk(k, p << (3 - t));
         @(posedge clk);
         fwr <= 1;
         @(posedge clk);
         fwr <= 0;
         ien <= 0;
         repeat (2) @(posedge clk);
         #1;
         chk({flag, req}, 0);
         @(posedge clk);
         clk_en <= 0;
         @(posedge clk);
         #1;
         k = cnt;
         repeat (8) @(posedge clk);
         #1;
         chk(cnt, k);
         @(posedge clk);
         clk_en <= 1;
         @(posedge clk);
         en <= 0;
         repeat (4) @(posedge clk);
         #1;
         chk(pin, gpio);
      end
      tally_and_finish();
   end
endmodule // six_channel_pwm_timer_tb
`default_nettype wire
